/* design/djk_dual_jk.sv */
// Top of the dual J-K flip-flop block with active-low preset
//
// Operation
// R1 - Two identical, fully independent flip-flop cells
// R2 - Sample J/K high, update on falling edge
// R3 - J/K only valid during preceding high phase
// R4 - J-only sets, K-only clears; complement follows
// R5 - J,K low or no falling edge: hold
// R6 - J,K both high at falling edge: toggle
// R7 - Preset low forces true high, inverted low
// R8 - Driver keeps preset high for normal use
// R9 - Inverted output is always true's complement
`timescale 1ns/1ps
module djk_dual_jk #(
  parameter int unsigned N = djk_pkg::FF_COUNT
) (
  // System clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Per-cell flip-flop clocks, falling edge active
  input  wire logic [N-1:0] tck_in,
  // Per-cell data inputs
  input  wire logic [N-1:0] j_in,
  input  wire logic [N-1:0] k_in,
  // Per-cell preset, active low
  input  wire logic [N-1:0] set_n_in,
  // Per-cell outputs
  output logic      [N-1:0] q_out,
  output logic      [N-1:0] q_n_out
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rst_n;  // Synchronised reset used everywhere below

  // Release through two flops so all cells leave reset together.
  // The cells start from a known state here; the real part has none,
  // so nothing downstream may rely on the value chosen.
  djk_rst_sync #(
    .STAGES (djk_pkg::SYNC_STAGES)
  ) u_rst_sync (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .rst_sync_n_out (rst_n)
  );

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Falling edge of a cell clock seen between two samples
  function automatic logic fell(input logic prev, input logic now);
    fell = prev & ~now;
  endfunction

  // New true output for a falling edge with preset high
  function automatic logic jk_next(input logic j, input logic k,
                                   input logic q);
    case ({j, k})
      2'h0:    jk_next = q;    // Hold
      2'h1:    jk_next = 1'h0; // Clear
      2'h2:    jk_next = 1'h1; // Set
      2'h3:    jk_next = ~q;   // Toggle
      default: jk_next = q;
    endcase
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  // Every cell's storage lives side by side in one record
  typedef struct packed {
    logic [N-1:0] prev_tck;  // Cell clock one cycle ago
    logic [N-1:0] j_smp;     // J caught in the high phase
    logic [N-1:0] k_smp;     // K caught in the high phase
    logic [N-1:0] q;         // True outputs
    logic [N-1:0] q_n;       // Inverted outputs
  } djk_state_t;

  djk_state_t state;       // Registered state
  djk_state_t next_state;  // Next state

  // ==========================================================
  // Cell behaviour
  // ==========================================================
  // One pass per cell; no cell reads another's bits
  always_comb begin
    next_state          = state;
    next_state.prev_tck = tck_in;
    // R1 independent cells
    for (int i = 0; i < N; i++) begin
      // R2 R3 capture only while clock high
      if (tck_in[i]) begin
        next_state.j_smp[i] = j_in[i];
        next_state.k_smp[i] = k_in[i];
      end
      // R7 preset overrides any edge or hold on the outputs
      if (!set_n_in[i]) begin
        next_state.q[i]   = 1'h1;
        next_state.q_n[i] = 1'h0;
      // R4 R5 R6 act on the falling edge only
      end else if (fell(state.prev_tck[i], tck_in[i])) begin
        next_state.q[i]   = jk_next(state.j_smp[i], state.k_smp[i],
                                    state.q[i]);
        // R9 complement tracks the true output
        next_state.q_n[i] = ~jk_next(state.j_smp[i], state.k_smp[i],
                                     state.q[i]);
      end else begin
        // R5 no falling edge, hold
        next_state.q[i]   = state.q[i];
        next_state.q_n[i] = state.q_n[i];
      end
    end
  end

  // Register the record; reset gives a defined, complementary state
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state.prev_tck <= {N{djk_pkg::TCK_RESET}};
      state.j_smp    <= {N{djk_pkg::JK_RESET}};
      state.k_smp    <= {N{djk_pkg::JK_RESET}};
      state.q        <= {N{djk_pkg::Q_RESET}};
      state.q_n      <= {N{~djk_pkg::Q_RESET}};
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the flops
  assign q_out   = state.q;
  assign q_n_out = state.q_n;

  // ==========================================================
  // Checks
  // ==========================================================
  // Preset response costs one system clock: a limitation of
  // sampling the pins synchronously, traded for a glitch-free core.
  // Every check runs on the system clock, so a cell clock edge or a
  // preset shows in the outputs one cycle after it is first seen.
  for (genvar g = 0; g < N; g++) begin : g_chk
    // R7 preset forces outputs
    chk_preset_force: assert property ( // R7
      @(posedge clk_in) disable iff (!rst_n)
      !set_n_in[g] |=> (q_out[g] && !q_n_out[g]))
      else $error("preset did not force outputs");

    // R9 outputs stay complementary
    chk_out_compl: assert property ( // R9
      @(posedge clk_in) disable iff (!rst_n)
      q_n_out[g] == ~q_out[g])
      else $error("outputs not complementary");

    // R2 R3 update from high sample
    chk_jk_sample: assert property ( // R2 R3
      @(posedge clk_in) disable iff (!rst_n)
      (tck_in[g] ##1 (set_n_in[g] && !tck_in[g] && !j_in[g]))
        |=> (q_out[g] == $past(j_in[g], 2) ||
             $past(k_in[g], 2) == $past(j_in[g], 2) ||
             (!$past(k_in[g], 2) && !$past(j_in[g], 2))))
      else $error("update not from high-phase sample");

    // R4 clear on edge
    chk_clear_edge: assert property ( // R4
      @(posedge clk_in) disable iff (!rst_n)
      (set_n_in[g] && fell(state.prev_tck[g], tck_in[g]) &&
       !state.j_smp[g] && state.k_smp[g]) |=> !q_out[g])
      else $error("clear on edge failed");

    // R4 set on edge
    chk_set_edge: assert property ( // R4
      @(posedge clk_in) disable iff (!rst_n)
      (set_n_in[g] && fell(state.prev_tck[g], tck_in[g]) &&
       state.j_smp[g] && !state.k_smp[g]) |=> q_out[g])
      else $error("set on edge failed");

    // R5 hold with J,K low
    chk_hold_low: assert property ( // R5
      @(posedge clk_in) disable iff (!rst_n)
      (set_n_in[g] && fell(state.prev_tck[g], tck_in[g]) &&
       !state.j_smp[g] && !state.k_smp[g]) |=> $stable(q_out[g]))
      else $error("hold with J,K low failed");

    // R5 hold without edge
    chk_hold_noedge: assert property ( // R5
      @(posedge clk_in) disable iff (!rst_n)
      (set_n_in[g] && !fell(state.prev_tck[g], tck_in[g]))
        |=> $stable(q_out[g]) && $stable(q_n_out[g]))
      else $error("output moved without falling edge");

    // R6 toggle on edge
    chk_toggle_edge: assert property ( // R6
      @(posedge clk_in) disable iff (!rst_n)
      (set_n_in[g] && fell(state.prev_tck[g], tck_in[g]) &&
       state.j_smp[g] && state.k_smp[g])
        |=> q_out[g] != $past(q_out[g]))
      else $error("toggle failed");

    // R2 capture while clock high
    chk_jk_capture: assert property ( // R2
      @(posedge clk_in) disable iff (!rst_n)
      tck_in[g] |=> (state.j_smp[g] == $past(j_in[g]) &&
                     state.k_smp[g] == $past(k_in[g])))
      else $error("J/K not captured in high phase");

    // R3 ignore J/K while low
    chk_jk_ignore: assert property ( // R3
      @(posedge clk_in) disable iff (!rst_n)
      !tck_in[g] |=> ($stable(state.j_smp[g]) &&
                      $stable(state.k_smp[g])))
      else $error("J/K taken while clock low");

    // R5 rising edge holds outputs
    chk_rise_hold: assert property ( // R5
      @(posedge clk_in) disable iff (!rst_n)
      (set_n_in[g] && !state.prev_tck[g] && tck_in[g])
        |=> ($stable(q_out[g]) && $stable(q_n_out[g])))
      else $error("output moved on rising edge");

    // R7 preset beats an edge
    chk_preset_edge: assert property ( // R7
      @(posedge clk_in) disable iff (!rst_n)
      (!set_n_in[g] && fell(state.prev_tck[g], tck_in[g]))
        |=> (q_out[g] && !q_n_out[g]))
      else $error("edge overrode preset");
  end

endmodule

/* inc/djk_pkg.sv */
// Shared constants for the dual J-K flip-flop block
package djk_pkg;

  // ==========================================================
  // Structure
  // ==========================================================
  // Number of independent flip-flop cells
  localparam int unsigned FF_COUNT    = 2;
  // Depth of the reset release synchroniser
  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================================
  // Reset values
  // ==========================================================
  // True output after reset; the part itself powers up undefined
  localparam logic        Q_RESET     = 1'h0;
  // Flip-flop clock input is taken as low after reset
  localparam logic        TCK_RESET   = 1'h0;
  // Sampled J and K after reset
  localparam logic        JK_RESET    = 1'h0;

  // ==========================================================
  // Timing
  // ==========================================================
  // System clock period in ns
  localparam int unsigned CLK_PERIOD_NS  = 100;
  // Time in ns from a preset or an edge to the outputs, and the same in cycles
  localparam int unsigned RESPONSE_NS    = 100;
  localparam int unsigned RESPONSE_CYC   =
    (RESPONSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* design/djk_rst_sync.sv */
// Reset release synchroniser for the dual J-K block
`timescale 1ns/1ps
module djk_rst_sync #(
  parameter int unsigned STAGES = djk_pkg::SYNC_STAGES
) (
  // Clock and raw reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Synchronised reset
  output logic      rst_sync_n_out
);

  // ==========================================================
  // State
  // ==========================================================
  // Shift chain; assert is immediate, release is clocked
  typedef struct packed {
    logic [STAGES-1:0] chain;
  } djk_sync_state_t;

  djk_sync_state_t state;       // Registered chain
  djk_sync_state_t next_state;  // Next chain value

  // Shift a one in from the bottom
  always_comb begin
    next_state       = state;
    next_state.chain = {state.chain[STAGES-2:0], 1'h1};
  end

  // Asynchronous assert, constant load only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Last stage is the released reset
  assign rst_sync_n_out = state.chain[STAGES-1];

endmodule

/* bench/djk_drv.sv */
// Model of the logic driving both flip-flop cells
`timescale 1ns/1ps
module djk_drv (
  // System clock
  input  wire logic       clk_in,
  // Cell controls
  output logic      [1:0] tck_out,
  output logic      [1:0] j_out,
  output logic      [1:0] k_out,
  output logic      [1:0] set_n_out
);
  // ==========================================================
  // Idle levels
  // ==========================================================
  // preset held high
  initial begin
    tck_out   = 2'h0;
    j_out     = 2'h0;
    k_out     = 2'h0;
    set_n_out = 2'h3;
  end

  // ==========================================================
  // Stimulus tasks
  // ==========================================================
  // One clock pulse; J/K flipped once low so stale data is not trusted
  task automatic pulse(input int c, input logic jv, input logic kv);
    @(negedge clk_in);
    tck_out[c] = 1'h1;
    j_out[c]   = jv;
    k_out[c]   = kv;
    @(negedge clk_in);
    tck_out[c] = 1'h0;
    j_out[c]   = ~jv;
    k_out[c]   = ~kv;
  endtask

  // Preset level change
  task automatic preset(input int c, input logic v);
    @(negedge clk_in);
    set_n_out[c] = v;
  endtask
endmodule

/* bench/djk_dual_jk_tb_top.sv */
// Self-checking bench for the dual J-K flip-flop block
`timescale 1ns/1ps
module djk_dual_jk_tb_top;
  // ==========================================================
  // Signals
  // ==========================================================
  logic       clk_in = 1'h0;    // 10 MHz system clock
  logic       rst_n_in;         // Raw reset, active low
  logic [1:0] tck;              // Cell clocks
  logic [1:0] j;                // Cell J
  logic [1:0] k;                // Cell K
  logic [1:0] set_n;            // Cell presets
  logic [1:0] q;                // True outputs
  logic [1:0] q_n;              // Inverted outputs
  logic [1:0] exp_q;            // Expected true outputs
  int         n_mismatch;       // Mismatch count
  int         samples_checked;  // Comparison count

  // Clock, half period 50 ns
  always #50 clk_in = ~clk_in;

  djk_dual_jk #(.N(2)) djk_dual_jk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .tck_in(tck), .j_in(j), .k_in(k), .set_n_in(set_n),
    .q_out(q), .q_n_out(q_n));
  djk_drv djk_drv_i (.clk_in(clk_in), .tck_out(tck), .j_out(j),
    .k_out(k), .set_n_out(set_n));

  // ==========================================================
  // Checking helpers
  // ==========================================================
  task automatic chk(input string name, input logic [1:0] seen,
                     input logic [1:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, expv, seen);
    end
  endtask

  // Both outputs against the expected state
  task automatic chk_q();
    chk("q_out", q, exp_q);
    chk("q_n_out", q_n, ~exp_q);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  // Outputs settle to the chosen reset state
  task automatic t_reset();
    chk_q();
  endtask

  // Set, toggle both ways, hold high, clear, hold low on each cell
  task automatic t_modes();
    logic [11:0] seq;
    logic [1:0]  m;
    seq = 12'h13E;
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 6; s++) begin
        m = seq[2*s +: 2];
        djk_drv_i.pulse(c, m[1], m[0]);
        chk_q();
        case (m)
          2'h1: exp_q[c] = 1'h0;
          2'h2: exp_q[c] = 1'h1;
          2'h3: exp_q[c] = ~exp_q[c];
          default: exp_q[c] = exp_q[c];
        endcase
        @(negedge clk_in);
        chk_q();
      end
    end
  endtask

  // Preset forces high and overrides a clear edge; release restores
  task automatic t_preset();
    djk_drv_i.preset(1, 1'h0);
    exp_q[1] = 1'h1;
    @(negedge clk_in);
    chk_q();
    djk_drv_i.pulse(1, 1'h0, 1'h1);
    @(negedge clk_in);
    chk_q();
    djk_drv_i.preset(1, 1'h1);
    @(negedge clk_in);
    chk_q();
    djk_drv_i.pulse(1, 1'h0, 1'h1);
    exp_q[1] = 1'h0;
    @(negedge clk_in);
    chk_q();
  endtask

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    rst_n_in        = 1'h0;
    exp_q           = 2'h0;
    n_mismatch      = 0;
    samples_checked = 0;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'h1;
    repeat (3) @(negedge clk_in);
    t_reset();
    t_modes();
    t_preset();
    end_sim();
  end

  // Hang guard, far beyond the sequence length
  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end
endmodule
